// ### mtsd_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mtsd_bus_if;
    logic [31:0] instr;
    logic [31:0] flags;
    logic        pass;
    logic [2:0]  cls;
    logic        is_load;
    logic        pre;
    logic        up;
    modport dec (input instr, input flags, output pass, output cls,
                 output is_load, output pre, output up);
    modport core (output instr, output flags, input pass, input cls,
                  input is_load, input pre, input up);
endinterface
`default_nettype wire

// ### mtsd_core.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Block transfers decode load, pre-index and up bits from the instruction.
// - Full stack means pre-index on store; empty stack the opposite.
// - Ascending stores go up, loads down; descending the reverse.
// - Every instruction here runs only when its condition passes.
// - Swap is a read then write, never split by an interrupt.
// - Swap reads at base, writes source there, old data to destination.
// - Same source and destination register still ends with old memory.
// - Lock stays high across both swap accesses.
// - Byte-select picks byte or word; lanes follow endian setting.
// - Abort on swap read, write or both takes the data abort trap.
// - Swap costs one S, two N and one I cycle.
// - Software trap enters supervisor, saves status, jumps to 0x08.
// - Supervisor link gets the address after the trapping instruction.
// - Flag-setting move of link into PC returns and restores status.
// - Low 24 bits of a software trap are ignored.
// - Software trap costs two S and one N cycle.
// - Coprocessor data op is not waited on; it is flagged on coproc_issue_o and traps undefined.
// - With no coprocessor every coprocessor instruction traps undefined.
module mtsd_core
    import mtsd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Instruction issue
    input  wire logic        instr_valid_i,
    input  wire logic [31:0] instr_i,
    input  wire logic [31:0] instr_addr_i,
    input  wire logic        big_endian_i,
    input  wire logic        irq_i,
    output logic             instr_ready_o,
    // Register file read/write
    output logic [3:0]       rf_raddr_a_o,
    output logic [3:0]       rf_raddr_b_o,
    input  wire logic [31:0] rf_rdata_a_i,
    input  wire logic [31:0] rf_rdata_b_i,
    output logic             rf_we_o,
    output logic [3:0]       rf_waddr_o,
    output logic [31:0]      rf_wdata_o,
    // Memory bus
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic             mem_byte_o,
    output logic [31:0]      mem_addr_o,
    output logic [31:0]      mem_wdata_o,
    output logic             mem_lock_o,
    input  wire logic [31:0] mem_rdata_i,
    input  wire logic        mem_abort_i,
    // Multiple transfer decode
    output logic             multi_valid_o,
    output logic             multi_load_o,
    output logic             multi_pre_o,
    output logic             multi_up_o,
    // Processor state
    output logic [31:0]      pc_o,
    output logic [31:0]      status_o,
    output logic [31:0]      saved_status_o,
    output logic [31:0]      link_o,
    output logic             irq_taken_o,
    output logic             coproc_issue_o
);
    typedef enum logic [2:0] {
        MTSD_IDLE, MTSD_SW_READ, MTSD_SW_WRITE, MTSD_SW_INT,
        MTSD_TRAP_S1, MTSD_TRAP_S2
    } mtsd_state_t;

    mtsd_state_t  state;
    mtsd_bus_if   dbus ();
    logic [31:0]  pc;
    logic [31:0]  status;
    logic [31:0]  saved_status;
    logic [31:0]  link;
    logic [31:0]  swap_addr;
    logic [31:0]  swap_src;
    logic [31:0]  swap_old;
    logic [3:0]   swap_dest;
    logic         swap_byte;
    logic         swap_abort;
    logic [1:0]   lane;
    logic         take;
    logic         irq_s1;
    logic         irq_s2;
    logic         irq_s3;
    logic         irq_lvl;
    logic [31:0]  rd_byte;
    logic [31:0]  next_pc;

    assign dbus.instr  = instr_i;
    assign dbus.flags  = status;

    mtsd_decode u_dec (
        .d (dbus.dec)
    );

    // Interrupt pin synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_s1 <= 1'b0;
            irq_s2 <= 1'b0;
            irq_s3 <= 1'b0;
            irq_lvl <= 1'b0;
        end else begin
            irq_s1 <= irq_i;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
            if (irq_s2 == irq_s3) begin
                irq_lvl <= irq_s3;
            end
        end
    end

    assign instr_ready_o = (state == MTSD_IDLE);
    assign take          = instr_valid_i && instr_ready_o;
    assign next_pc       = instr_addr_i + WORD_STEP;

    assign multi_valid_o = take && dbus.pass
                           && dbus.cls == MTSD_CLS_MULTI;
    assign multi_load_o  = dbus.is_load;
    assign multi_pre_o   = dbus.pre;
    assign multi_up_o    = dbus.up;

    // Register file reads
    always_comb begin
        rf_raddr_a_o = instr_i[RN_LSB +: 4];
        rf_raddr_b_o = instr_i[RM_LSB +: 4];
    end

    assign lane = big_endian_i ? ~swap_addr[1:0] : swap_addr[1:0];
    always_comb begin
        rd_byte = {24'h000000, mem_rdata_i[{lane, 3'h0} +: 8]};
    end

    // Swap and trap sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= MTSD_IDLE;
        end else begin
            case (state)
                MTSD_IDLE: begin
                    if (take && dbus.pass && dbus.cls == MTSD_CLS_SWAP) begin
                        state <= MTSD_SW_READ;
                    end else if (take && dbus.pass
                                 && dbus.cls == MTSD_CLS_TRAP) begin
                        state <= MTSD_TRAP_S1;
                    end
                end
                // N read, N write, I, then S
                MTSD_SW_READ:  state <= MTSD_SW_WRITE;
                MTSD_SW_WRITE: state <= MTSD_SW_INT;
                MTSD_SW_INT:   state <= MTSD_IDLE;
                MTSD_TRAP_S1:  state <= MTSD_TRAP_S2;
                MTSD_TRAP_S2:  state <= MTSD_IDLE;
                default:       state <= MTSD_IDLE;
            endcase
        end
    end

    // Swap operand capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swap_addr  <= 32'h00000000;
            swap_src   <= 32'h00000000;
            swap_old   <= 32'h00000000;
            swap_dest  <= 4'h0;
            swap_byte  <= 1'b0;
            swap_abort <= 1'b0;
        end else begin
            if (state == MTSD_IDLE) begin
                swap_addr  <= rf_rdata_a_i;
                swap_src   <= rf_rdata_b_i;
                swap_dest  <= instr_i[RD_LSB +: 4];
                swap_byte  <= instr_i[BIT_B];
                swap_abort <= 1'b0;
            end
            if (state == MTSD_SW_READ) begin
                // old value held apart from source
                swap_old <= swap_byte ? rd_byte : mem_rdata_i;
            end
            if ((state == MTSD_SW_READ || state == MTSD_SW_WRITE)
                && mem_abort_i) begin
                swap_abort <= 1'b1;
            end
        end
    end

    // Memory bus drive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_byte_o  <= 1'b0;
            mem_addr_o  <= 32'h00000000;
            mem_wdata_o <= 32'h00000000;
            mem_lock_o  <= 1'b0;
        end else begin
            mem_req_o  <= 1'b0;
            mem_we_o   <= 1'b0;
            mem_lock_o <= 1'b0;
            if (state == MTSD_IDLE && take && dbus.pass
                && dbus.cls == MTSD_CLS_SWAP) begin
                mem_req_o  <= 1'b1;
                mem_lock_o <= 1'b1;
                mem_addr_o <= rf_rdata_a_i;
                mem_byte_o <= instr_i[BIT_B];
            end else if (state == MTSD_SW_READ) begin
                mem_req_o   <= 1'b1;
                mem_we_o    <= 1'b1;
                mem_lock_o  <= 1'b1;
                mem_wdata_o <= swap_byte ? {4{swap_src[7:0]}} : swap_src;
            end
        end
    end

    // Destination register write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rf_we_o    <= 1'b0;
            rf_waddr_o <= 4'h0;
            rf_wdata_o <= 32'h00000000;
        end else begin
            rf_we_o <= 1'b0;
            if (state == MTSD_SW_INT && !swap_abort) begin
                rf_we_o    <= 1'b1;
                rf_waddr_o <= swap_dest;
                rf_wdata_o <= swap_old;
            end
        end
    end

    // Program counter, status, banked registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc           <= PC_RST;
            status       <= STATUS_RST;
            saved_status <= 32'h00000000;
            link         <= 32'h00000000;
            irq_taken_o  <= 1'b0;
        end else begin
            irq_taken_o <= 1'b0;
            if (take) begin
                pc <= next_pc;
                if (dbus.pass) begin
                    case (dbus.cls)
                        MTSD_CLS_TRAP: begin
                            saved_status <= status;
                            status[MODE_LSB +: MODE_W] <= MODE_SVC;
                            status[IRQ_DIS] <= 1'b1;
                            link <= next_pc;
                            pc   <= VEC_TRAP;
                        end
                        MTSD_CLS_COPROC: begin
                            saved_status <= status;
                            status[MODE_LSB +: MODE_W] <= MODE_SVC;
                            status[IRQ_DIS] <= 1'b1;
                            link <= next_pc;
                            pc   <= VEC_UNDEF;
                        end
                        MTSD_CLS_RETURN: begin
                            pc     <= link;
                            status <= saved_status;
                        end
                        default: begin
                        end
                    endcase
                end else if (irq_lvl && !status[IRQ_DIS]) begin
                    irq_taken_o <= 1'b1;
                end
            end else if (state == MTSD_SW_INT && swap_abort) begin
                saved_status <= status;
                status[MODE_LSB +: MODE_W] <= MODE_SVC;
                status[IRQ_DIS] <= 1'b1;
                pc <= VEC_DABT;
            end
        end
    end

    assign coproc_issue_o = take && dbus.pass && dbus.cls == MTSD_CLS_COPROC;

    assign pc_o           = pc;
    assign status_o       = status;
    assign saved_status_o = saved_status;
    assign link_o         = link;
endmodule
`default_nettype wire

// ### mtsd_core_checker.sv
`timescale 1ns/1ns
`default_nettype none
module mtsd_core_checker
    import mtsd_pkg::*;
(
    // Clock, reset and issue
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic [31:0] instr_addr_i,
    input wire logic        instr_ready_o,
    // Bus and state
    input wire logic        mem_req_o,
    input wire logic        mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic        mem_lock_o,
    input wire logic        mem_abort_i,
    input wire logic [31:0] pc_o,
    input wire logic [31:0] status_o,
    input wire logic [31:0] link_o,
    input wire logic        irq_taken_o
);
    logic take, run_c, swap_c;
    assign take = instr_valid_i && instr_ready_o;
    assign run_c = instr_i[31:28] == 4'hE;
    assign swap_c = instr_i[27:23] == 5'h02 && instr_i[21:20] == 2'h0
                    && instr_i[11:4] == 8'h09;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_lock_pair: assert property (
        $rose(mem_lock_o) |-> mem_req_o && !mem_we_o ##1 mem_lock_o
        && mem_req_o && mem_we_o ##1 !mem_lock_o) else $error("lock gap");
    a_same_addr: assert property (
        mem_lock_o && !mem_we_o |=> mem_addr_o == $past(mem_addr_o))
        else $error("swap write address moved");
    a_no_irq_lock: assert property (
        mem_lock_o |-> !irq_taken_o) else $error("irq inside swap");
    a_swap_busy: assert property (
        take && run_c && swap_c |=> !instr_ready_o [*3] ##1 instr_ready_o)
        else $error("swap length wrong");
    a_trap_entry: assert property (
        take && run_c && instr_i[27:24] == 4'hF |=> pc_o == VEC_TRAP
        && status_o[4:0] == MODE_SVC && !instr_ready_o
        && link_o == $past(instr_addr_i) + WORD_STEP
        ##1 !instr_ready_o ##1 instr_ready_o) else $error("trap entry");
    a_abort_trap: assert property (
        mem_req_o && mem_abort_i |-> ##[1:3] pc_o == VEC_DABT)
        else $error("abort not trapped");
    a_cond_skip: assert property (
        take && instr_i[31:28] == 4'h0 && !status_o[FLAG_Z] |=> !mem_req_o
        && pc_o == $past(instr_addr_i) + WORD_STEP) else $error("no skip");
    a_coproc_undef: assert property (
        take && run_c && instr_i[27:24] == 4'hE && !instr_i[4]
        |=> pc_o == VEC_UNDEF) else $error("coproc not trapped");
endmodule
bind mtsd_core mtsd_core_checker chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_addr_i(instr_addr_i),
    .instr_ready_o(instr_ready_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_lock_o(mem_lock_o),
    .mem_abort_i(mem_abort_i), .pc_o(pc_o), .status_o(status_o),
    .link_o(link_o), .irq_taken_o(irq_taken_o));
`default_nettype wire

// ### mtsd_core_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module mtsd_core_tb_top
    import mtsd_pkg::*;
;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        instr_valid_i = 1'h0;
    logic        big_endian_i = 1'h0;
    logic        irq_i = 1'h0;
    logic [1:0]  abort_sel = 2'h0;
    logic [31:0] instr_i = 32'h0;
    logic [31:0] instr_addr_i = 32'h0;
    logic [31:0] rf [16];
    logic [31:0] wd, adr, wdat, rdat, pc_o, status_o, saved_o, link_o, st, lk;
    logic [3:0]  ra, rb, wa;
    logic        instr_ready_o, rf_we, req, we, byt, abt, mv, ml, mp, mu, cop;
    logic        lock;
    int          lock_n = 0;
    logic [4:0]  seen;
    int          miscompares = 0;
    int          tests_run = 0;

    mtsd_core dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .instr_addr_i(instr_addr_i),
        .big_endian_i(big_endian_i), .irq_i(irq_i),
        .instr_ready_o(instr_ready_o), .rf_raddr_a_o(ra), .rf_raddr_b_o(rb),
        .rf_rdata_a_i(rf[ra]), .rf_rdata_b_i(rf[rb]), .rf_we_o(rf_we),
        .rf_waddr_o(wa), .rf_wdata_o(wd), .mem_req_o(req), .mem_we_o(we),
        .mem_byte_o(byt), .mem_addr_o(adr), .mem_wdata_o(wdat),
        .mem_lock_o(lock), .mem_rdata_i(rdat), .mem_abort_i(abt),
        .multi_valid_o(mv), .multi_load_o(ml), .multi_pre_o(mp),
        .multi_up_o(mu), .pc_o(pc_o), .status_o(status_o),
        .saved_status_o(saved_o), .link_o(link_o), .irq_taken_o(),
        .coproc_issue_o(cop));
    mtsd_mem_model mem_u (
        .clk_i(clk_i), .mem_req_i(req), .mem_we_i(we), .mem_byte_i(byt),
        .big_endian_i(big_endian_i), .mem_addr_i(adr), .mem_wdata_i(wdat),
        .abort_sel_i(abort_sel), .mem_rdata_o(rdat), .mem_abort_o(abt));

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (rf_we === 1'h1) rf[wa] <= wd;
        if (lock === 1'h1) lock_n <= lock_n + 1;
    end

    task automatic complete_run();
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Offer one instruction, wait until the core is idle again
    task automatic issue(input logic [31:0] ins, input logic [31:0] at);
        int n;
        @(posedge clk_i);
        instr_valid_i <= 1'h1;
        instr_i <= ins;
        instr_addr_i <= at;
        @(negedge clk_i);
        seen = {cop, mv, ml, mp, mu};
        @(posedge clk_i);
        instr_valid_i <= 1'h0;
        for (n = 0; n < 20; n++) begin
            @(negedge clk_i);
            if (instr_ready_o === 1'h1) break;
        end
        if (n == 20) begin
            miscompares++;
            complete_run();
        end
    endtask

    task automatic swap(input logic [3:0] bse, dst, srcr, input logic bsel,
                        input logic be, input logic [1:0] ab,
                        input logic [31:0] at);
        logic [31:0] old, src, er, em, prev;
        logic [1:0]  ln;
        @(posedge clk_i);
        big_endian_i <= be;
        abort_sel <= ab;
        irq_i <= 1'h1;
        lock_n <= 0;
        rf[bse] <= at;
        src = rf[srcr];
        prev = rf[dst];
        old = mem_u.mem[at[5:2]];
        ln = at[1:0] ^ {2{be}};
        er = bsel ? {24'h0, old[ln*8 +: 8]} : old;
        em = old;
        if (bsel) em[ln*8 +: 8] = src[7:0];
        else em = src;
        issue({4'hE, 5'h02, bsel, 2'h0, bse, dst, 8'h09, srcr}, 32'h200);
        @(negedge clk_i);
        check("swap lock", lock_n, 32'h2);
        if (ab == 2'h0) begin
            check("swap dest", rf[dst], er);
            check("swap mem", mem_u.mem[at[5:2]], em);
        end else begin
            check("abort pc", pc_o, VEC_DABT);
            check("abort dest", rf[dst], prev);
        end
    endtask

    initial begin
        for (int i = 0; i < 16; i++) rf[i] = 32'h0BAD0000 + i * 32'h111;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        issue(32'h08900001, 32'h100);
        check("skip decode", seen[3], 1'h0);
        check("skip pc", pc_o, 32'h104);
        for (int i = 0; i < 8; i++) begin
            issue({4'hE, 3'h4, i[1], i[0], 2'h0, i[2], 20'h10001}, 32'h100);
            check("multi", seen[3:0], {1'h1, i[2], i[1], i[0]});
        end
        swap(4'h2, 4'h4, 4'h3, 1'h0, 1'h0, 2'h0, 32'h20);
        swap(4'h2, 4'h5, 4'h5, 1'h0, 1'h0, 2'h0, 32'h24);
        swap(4'h2, 4'h6, 4'h7, 1'h1, 1'h0, 2'h0, 32'h29);
        swap(4'h2, 4'h6, 4'h7, 1'h1, 1'h1, 2'h0, 32'h2A);
        for (int k = 1; k < 4; k++) begin
            swap(4'h2, 4'h8, 4'h9, 1'h0, 1'h0, k[1:0], 32'h30);
        end
        issue({8'h0F, 24'h0}, 32'h600);
        check("skip trap pc", pc_o, 32'h604);
        check("skip trap link", link_o, 32'h0);
        issue({4'h0, 5'h02, 3'h0, 8'h24, 8'h09, 4'h3}, 32'h700);
        check("skip swap pc", pc_o, 32'h704);
        for (int k = 0; k < 2; k++) begin
            st = status_o;
            issue({8'hEF, {24{k[0]}}}, 32'h300);
            check("trap pc", pc_o, VEC_TRAP);
            check("trap link", link_o, 32'h304);
            check("trap saved", saved_o, st);
            check("trap mode", status_o[4:0], MODE_SVC);
        end
        st = saved_o;
        lk = link_o;
        issue(32'hE1B0F00E, 32'h400);
        check("return pc", pc_o, lk);
        check("return status", status_o, st);
        issue(32'hEE123045, 32'h500);
        check("coproc issue", seen[4], 1'h1);
        check("coproc trap", pc_o, VEC_UNDEF);
        complete_run();
    end
endmodule
`default_nettype wire

// ### mtsd_decode.sv
`timescale 1ns/1ns
`default_nettype none
module mtsd_decode
    import mtsd_pkg::*;
(
    mtsd_bus_if.dec d
);
    logic       n, z, c, v;
    logic [3:0] cond;
    assign n = d.flags[FLAG_N];
    assign z = d.flags[FLAG_Z];
    assign c = d.flags[FLAG_C];
    assign v = d.flags[FLAG_V];
    assign cond = d.instr[31:28];

    always_comb begin
        case (cond)
            4'h0:    d.pass = z;
            4'h1:    d.pass = !z;
            4'h2:    d.pass = c;
            4'h3:    d.pass = !c;
            4'h4:    d.pass = n;
            4'h5:    d.pass = !n;
            4'h6:    d.pass = v;
            4'h7:    d.pass = !v;
            4'h8:    d.pass = c && !z;
            4'h9:    d.pass = !c || z;
            4'hA:    d.pass = n == v;
            4'hB:    d.pass = n != v;
            4'hC:    d.pass = !z && (n == v);
            4'hD:    d.pass = z || (n != v);
            4'hE:    d.pass = 1'b1;
            default: d.pass = 1'b0;
        endcase
    end

    // Class decode
    always_comb begin
        d.cls = MTSD_CLS_NONE;
        if (d.instr[27:25] == 3'h4) begin
            d.cls = MTSD_CLS_MULTI;
        end else if (d.instr[27:23] == 5'h02 && d.instr[21:20] == 2'h0
                     && d.instr[11:4] == 8'h09) begin
            d.cls = MTSD_CLS_SWAP;
        end else if (d.instr[27:24] == 4'hF) begin
            d.cls = MTSD_CLS_TRAP;
        end else if (d.instr[27:26] == 2'h3) begin
            d.cls = MTSD_CLS_COPROC;
        end else if (d.instr[27:20] == 8'h1B && d.instr[15:12] == 4'hF
                     && d.instr[11:0] == 12'h00E) begin
            d.cls = MTSD_CLS_RETURN;
        end
    end

    assign d.is_load = d.instr[BIT_L];
    assign d.pre = d.instr[BIT_P];
    assign d.up = d.instr[BIT_U];
endmodule
`default_nettype wire

// ### mtsd_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mtsd_mem_model (
    // Bus from the core
    input  wire logic        clk_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic        mem_byte_i,
    input  wire logic        big_endian_i,
    input  wire logic [31:0] mem_addr_i,
    input  wire logic [31:0] mem_wdata_i,
    input  wire logic [1:0]  abort_sel_i,
    // Answers
    output logic [31:0]      mem_rdata_o,
    output logic             mem_abort_o
);
    logic [31:0] mem [16];
    logic [31:0] last = 32'h0;
    logic        rd_d = 1'h0;
    logic [1:0]  lane;
    logic [3:0]  idx;
    assign idx = mem_addr_i[5:2];
    assign lane = mem_addr_i[1:0] ^ {2{big_endian_i}};
    assign mem_abort_o = mem_req_i && (abort_sel_i[mem_we_i]
                         || (rd_d && abort_sel_i[0]));
    // Idle bus shows inverted data
    assign mem_rdata_o = (mem_req_i && !mem_we_i) || rd_d ? mem[idx] : ~last;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 32'hA5000000 | (i * 32'h10203);
    end
    always @(posedge clk_i) begin
        rd_d <= mem_req_i && !mem_we_i;
        if (mem_req_i && !mem_we_i) last <= mem[idx];
        if (mem_req_i && mem_we_i && !mem_abort_o) begin
            if (mem_byte_i) mem[idx][lane*8 +: 8] <= mem_wdata_i[7:0];
            else mem[idx] <= mem_wdata_i;
        end
    end
endmodule
`default_nettype wire

// ### mtsd_pkg.sv
package mtsd_pkg;
    // Status register field positions
    localparam int MODE_LSB   = 0;
    localparam int MODE_W     = 5;
    localparam int IRQ_DIS    = 7;
    localparam int FLAG_V     = 28;
    localparam int FLAG_C     = 29;
    localparam int FLAG_Z     = 30;
    localparam int FLAG_N     = 31;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_USR = 5'h10;
    // Reset values
    localparam logic [31:0] STATUS_RST = 32'h000000D3;
    localparam logic [31:0] PC_RST     = 32'h00000000;
    // Trap vectors
    localparam logic [31:0] VEC_UNDEF  = 32'h00000004;
    localparam logic [31:0] VEC_TRAP   = 32'h00000008;
    localparam logic [31:0] VEC_DABT   = 32'h00000010;
    localparam logic [31:0] WORD_STEP  = 32'h00000004;
    // Instruction field positions
    localparam int COND_LSB   = 28;
    localparam int BIT_P      = 24;
    localparam int BIT_U      = 23;
    localparam int BIT_B      = 22;
    localparam int BIT_L      = 20;
    localparam int RN_LSB     = 16;
    localparam int RD_LSB     = 12;
    localparam int RM_LSB     = 0;
    localparam int CMT_W      = 24;
    // Cycle costs in S, N, I cycles
    localparam int SWAP_CYC   = 4;
    localparam int TRAP_CYC   = 3;
    // Instruction classes
    typedef enum logic [2:0] {
        MTSD_CLS_NONE, MTSD_CLS_MULTI, MTSD_CLS_SWAP,
        MTSD_CLS_TRAP, MTSD_CLS_COPROC, MTSD_CLS_RETURN
    } mtsd_cls_t;
endpackage
